// ==== irt_pkg.sv ====
// Purpose: shared constants of the infrared carrier timer block
// Assumes: one clock, mclk, standing in for the oscillator
// Notes: control word is ten bits wide
package irt_pkg;
  localparam int CNT_W = 9;
  localparam int CTL_W = 10;
  localparam int MC_DIV = 8;
  localparam int CAR_DIV_LO = 8;
  localparam int CAR_DIV_HI = 12;
  localparam int CAR_HI_LO = 4;
  localparam int CAR_HI_HI = 4;
  localparam int CTL_RL_SRC = 0;
  localparam int CTL_KEY_DIR = 1;
  localparam int CTL_RUN = 2;
  localparam int CTL_CAR_SEL = 3;
  localparam int CTL_PTR_LO = 4;
  localparam int CTL_PTR_HI = 5;
  localparam int CTL_STOP_OSC = 6;
  localparam logic [9:0] CTL_RESET = 10'h000;
  localparam logic [9:0] TMR_RESET = 10'h000;
  localparam logic [2:0] REL_SIN = 3'h0;
  localparam logic [2:0] REL_KEYSCAN = 3'h1;
  localparam logic [2:0] REL_KEYIN = 3'h2;
  localparam logic [2:0] REL_TIMER = 3'h3;
  typedef enum logic [1:0] {IRT_RUN, IRT_HALT, IRT_STOP_WAIT, IRT_STOP}
    irt_state_e;
endpackage

// ==== irt_div.sv ====
// Purpose: free running divide-by-n with one-cycle enable pulse
// Assumes: n is 1 to 15 and may change between periods
// Notes: pulse on the last count of each period
module irt_div (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] div_n,
  output logic [3:0] phase,
  output logic tick
);
  logic [3:0] cnt_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
    end else if (cnt_ff >= div_n - 4'h1) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  assign phase = cnt_ff;
  assign tick = (cnt_ff >= div_n - 4'h1);
endmodule

// ==== irt_timer.sv ====
// Purpose: transmit timer, control word and standby logic
// Assumes: instruction side gives one-cycle strobes for loads and halts
// Notes: stop mode is reported, the oscillator itself lives outside
// Notes on behaviour
// - counter steps down once per machine cycle
// - counter halts at zero, flags finished
// - load of n lasts n+1 machine cycles
// - timer completion releases timer-wait standby
// - reload while still counting keeps carrier
// - top timer bit enables the carrier
// - no carrier at zero; output low
// - activity pin is low while carrier runs
// - stop standby waits for count end
// - reset: carrier low, activity high, timer clear
// - control bit 2 runs or stops counting
// - control bit 3 picks divide 8 or 12
// - control bit 0 picks rotate source
// - control bit 1 sets key port direction
// - control bits 4,5 give pointer high bits
// - control bit 6 picks halt or stop
// - reset clears control bits 0, 8, 9
// - halt operand picks release source, level
// - key port release only in input mode
// - standby pauses program, keeps state
// - low all-clear resets internals
module irt_timer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic all_clear_n,
  input wire logic tmr_load,
  input wire logic [irt_pkg::CNT_W:0] tmr_wdata,
  input wire logic ctl_load,
  input wire logic [irt_pkg::CTL_W-1:0] ctl_wdata,
  input wire logic halt_req,
  input wire logic [3:0] halt_operand,
  input wire logic serial_in,
  input wire logic [7:0] key_scan_port,
  input wire logic [3:0] key_input_port,
  output logic ir_carrier_out,
  output logic tx_active_n,
  output logic [irt_pkg::CNT_W:0] tmr_rdata,
  output logic [irt_pkg::CTL_W-1:0] port_control,
  output logic tmr_done,
  output logic cpu_run,
  output logic osc_stopped,
  output logic rl_from_serial,
  output logic serial_pull_en,
  output logic key_scan_out_en,
  output logic [1:0] rom_ptr_hi
);
  import irt_pkg::*;

  logic rst_all_n;
  logic [3:0] mc_phase;
  logic mc_tick;
  logic [3:0] car_phase;
  logic car_tick;
  logic [CNT_W-1:0] cnt_ff;
  logic car_en_ff;
  logic [CTL_W-1:0] ctl_ff;
  irt_state_e state_ff;
  logic [3:0] hop_ff;
  logic car_ff;
  logic act_n_ff;
  logic done_ff;
  logic run_ff;
  logic stop_ff;
  logic [3:0] car_n;
  logic [3:0] car_hi;
  logic cnt_zero;
  logic pin_level;
  logic release_hit;
  logic nxt_car;

  // all-clear and system reset act alike
  assign rst_all_n = rst_n & all_clear_n;

  irt_div u_mc_div (
    .mclk(mclk),
    .rst_n(rst_all_n),
    .div_n(4'(MC_DIV)),
    .phase(mc_phase),
    .tick(mc_tick)
  );

  // divider keeps running across timer loads, so edge pulses may be short
  assign car_n = ctl_ff[CTL_CAR_SEL] ? 4'(CAR_DIV_HI) :
                 4'(CAR_DIV_LO);
  assign car_hi = ctl_ff[CTL_CAR_SEL] ? 4'(CAR_HI_HI) : 4'(CAR_HI_LO);
  irt_div u_car_div (
    .mclk(mclk),
    .rst_n(rst_all_n),
    .div_n(car_n),
    .phase(car_phase),
    .tick(car_tick)
  );

  assign cnt_zero = (cnt_ff == '0);

  // down counter; a load of n needs n+1 ticks to end
  always_ff @(posedge mclk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      cnt_ff <= TMR_RESET[CNT_W-1:0];
      car_en_ff <= TMR_RESET[CNT_W];
    end else if (tmr_load) begin
      cnt_ff <= tmr_wdata[CNT_W-1:0];
      car_en_ff <= tmr_wdata[CNT_W];
    end else if (mc_tick && ctl_ff[CTL_RUN] && !cnt_zero) begin
      cnt_ff <= cnt_ff - 9'h001;
    end
  end

  // finished flag marks the tick after the count reached zero
  always_ff @(posedge mclk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      done_ff <= 1'b1;
    end else if (tmr_load) begin
      done_ff <= 1'b0;
    end else if (mc_tick && cnt_zero) begin
      done_ff <= 1'b1;
    end
  end

  // control word; unmentioned bits clear too, which is one legal value
  always_ff @(posedge mclk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      ctl_ff <= CTL_RESET;
    end else if (ctl_load) begin
      ctl_ff <= ctl_wdata;
    end
  end

  // carrier runs while counting and enabled; reload keeps it going
  always_comb begin
    nxt_car = 1'b0;
    if (car_en_ff && !cnt_zero && ctl_ff[CTL_RUN]) begin
      nxt_car = (car_phase < car_hi);
    end
    if (tmr_load && !tmr_wdata[CNT_W]) begin
      nxt_car = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      car_ff <= 1'b0;
      act_n_ff <= 1'b1;
    end else begin
      car_ff <= nxt_car;
      act_n_ff <= !(car_en_ff && !cnt_zero && ctl_ff[CTL_RUN]);
    end
  end

  // release level from the selected source
  always_comb begin
    pin_level = 1'b0;
    release_hit = 1'b0;
    unique case (hop_ff[2:0])
      REL_SIN: begin
        pin_level = serial_in;
        // rotating from the accumulator leaves the pin floating
        release_hit = !ctl_ff[CTL_RL_SRC] ||
                      (pin_level == hop_ff[3]);
      end
      REL_KEYSCAN: begin
        pin_level = hop_ff[3] ? (|key_scan_port) : !(&key_scan_port);
        release_hit = !ctl_ff[CTL_KEY_DIR] && pin_level;
      end
      REL_KEYIN: begin
        pin_level = hop_ff[3] ? (|key_input_port) : !(&key_input_port);
        release_hit = pin_level;
      end
      REL_TIMER: begin
        release_hit = done_ff;
      end
      default: begin
        release_hit = 1'b0;
      end
    endcase
  end

  // standby sequencing; registers hold since only cpu_run pauses
  always_ff @(posedge mclk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      state_ff <= IRT_RUN;
      hop_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        IRT_RUN: begin
          if (halt_req) begin
            hop_ff <= halt_operand;
            state_ff <= ctl_ff[CTL_STOP_OSC] ?
                        IRT_STOP_WAIT : IRT_HALT;
          end
        end
        IRT_HALT: begin
          if (release_hit) begin
            state_ff <= IRT_RUN;
          end
        end
        IRT_STOP_WAIT: begin
          if (done_ff) begin
            state_ff <= IRT_STOP;
          end
        end
        IRT_STOP: begin
          if (release_hit) begin
            state_ff <= IRT_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      run_ff <= 1'b1;
      stop_ff <= 1'b0;
    end else begin
      run_ff <= (state_ff == IRT_RUN) && !halt_req;
      stop_ff <= (state_ff == IRT_STOP);
    end
  end

  assign ir_carrier_out = car_ff;
  assign tx_active_n = act_n_ff;
  assign tmr_rdata = {car_en_ff, cnt_ff};
  assign port_control = ctl_ff;
  assign tmr_done = done_ff;
  assign cpu_run = run_ff;
  assign osc_stopped = stop_ff;
  assign rl_from_serial = ctl_ff[CTL_RL_SRC];
  assign serial_pull_en = ctl_ff[CTL_RL_SRC];
  assign key_scan_out_en = ctl_ff[CTL_KEY_DIR];
  assign rom_ptr_hi = ctl_ff[CTL_PTR_HI:CTL_PTR_LO];

  count_down_a: assert property (@(posedge mclk) disable iff (!rst_all_n)
    mc_tick && ctl_ff[CTL_RUN] && !cnt_zero && !tmr_load |=>
    cnt_ff == $past(cnt_ff) - 9'h001)
    else $error("counter failed to step");
  zero_hold_a: assert property (@(posedge mclk) disable iff (!rst_all_n)
    cnt_zero && !tmr_load |=> cnt_zero)
    else $error("counter left zero without load");
  stop_gate_a: assert property (@(posedge mclk) disable iff (!rst_all_n)
    !ctl_ff[CTL_RUN] && !tmr_load |=> $stable(cnt_ff))
    else $error("counter moved while stopped");
  car_off_a: assert property (@(posedge mclk) disable iff (!rst_all_n)
    (cnt_zero || !car_en_ff) && !tmr_load |=> !ir_carrier_out)
    else $error("carrier without enable");
  act_inv_a: assert property (@(posedge mclk) disable iff (!rst_all_n)
    ir_carrier_out |-> !tx_active_n)
    else $error("activity not low during carrier");
  halt_timer_a: assert property (@(posedge mclk) disable iff (!rst_all_n)
    state_ff == IRT_HALT && hop_ff[2:0] == REL_TIMER && done_ff
    |=> state_ff == IRT_RUN ##1 cpu_run)
    else $error("timer release missed");
  stop_wait_a: assert property (@(posedge mclk) disable iff (!rst_all_n)
    state_ff == IRT_STOP_WAIT && !done_ff |=> !osc_stopped)
    else $error("oscillator stopped early");
  key_dir_a: assert property (@(posedge mclk) disable iff (!rst_all_n)
    state_ff == IRT_HALT && hop_ff[2:0] == REL_KEYSCAN && ctl_ff[CTL_KEY_DIR]
    |=> state_ff == IRT_HALT)
    else $error("key scan release in output mode");
  cov_carrier_c: cover property (@(posedge mclk) disable iff (!rst_all_n)
    ir_carrier_out ##1 !ir_carrier_out);
  cov_halt_c: cover property (@(posedge mclk) disable iff (!rst_all_n)
    state_ff == IRT_HALT ##1 state_ff == IRT_RUN);
  cov_stop_c: cover property (@(posedge mclk) disable iff (!rst_all_n)
    state_ff == IRT_STOP_WAIT ##1 state_ff == IRT_STOP);
endmodule

// ==== irt_key_model.sv ====
// Purpose: key matrix and infrared led seen from the pins
// Assumes: key pins pulled down while in input mode
// Notes: output mode shows inverted keys, no clean value
module irt_key_model (
  input wire logic mclk,
  input wire logic out_en,
  input wire logic [7:0] press_scan,
  input wire logic [3:0] press_in,
  input wire logic led_drive,
  output logic [7:0] key_scan_port,
  output logic [3:0] key_input_port,
  output int led_pulses
);
  logic led_q = 1'b0;
  int pulse_cnt = 0;
  // device drives the scan lines in output mode
  assign key_scan_port = out_en ? ~press_scan : press_scan;
  assign key_input_port = press_in;
  // one process owns the count; the port only mirrors it
  assign led_pulses = pulse_cnt;
  always @(posedge mclk) begin
    led_q <= led_drive;
    if (led_drive && !led_q) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end
endmodule

// ==== ir_carrier_timer_control_tb.sv ====
// Purpose: directed bench for the carrier timer block
// Assumes: inputs move on the falling edge
// Notes: machine tick phase unknown, time windows allow for it
module ir_carrier_timer_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import irt_pkg::*;
  logic mclk, rst_n, all_clear_n, tmr_load, ctl_load, halt_req;
  logic serial_in, ir_carrier_out, tx_active_n, tmr_done, cpu_run;
  logic osc_stopped, rl_from_serial, serial_pull_en, key_scan_out_en;
  logic [CNT_W:0] tmr_wdata, tmr_rdata;
  logic [CTL_W-1:0] ctl_wdata, port_control;
  logic [3:0] halt_operand, key_input_port, press_in;
  logic [7:0] key_scan_port, press_scan;
  logic [1:0] rom_ptr_hi;
  wire [2:0] st = {osc_stopped, cpu_run, tmr_done};
  int miscompares = 0, check_count = 0, n, p0, pulses;
  irt_timer irt_timer_i (.mclk(mclk), .rst_n(rst_n),
    .all_clear_n(all_clear_n), .tmr_load(tmr_load),
    .tmr_wdata(tmr_wdata), .ctl_load(ctl_load), .ctl_wdata(ctl_wdata),
    .halt_req(halt_req), .halt_operand(halt_operand),
    .serial_in(serial_in), .key_scan_port(key_scan_port),
    .key_input_port(key_input_port), .ir_carrier_out(ir_carrier_out),
    .tx_active_n(tx_active_n), .tmr_rdata(tmr_rdata),
    .port_control(port_control), .tmr_done(tmr_done), .cpu_run(cpu_run),
    .osc_stopped(osc_stopped), .rl_from_serial(rl_from_serial),
    .serial_pull_en(serial_pull_en), .key_scan_out_en(key_scan_out_en),
    .rom_ptr_hi(rom_ptr_hi));
  irt_key_model irt_key_model_i (.mclk(mclk), .out_en(key_scan_out_en),
    .press_scan(press_scan), .press_in(press_in),
    .led_drive(ir_carrier_out), .key_scan_port(key_scan_port),
    .key_input_port(key_input_port), .led_pulses(pulses));
  task automatic check(string what, logic [11:0] got, logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic ctl(logic [9:0] v);
    ctl_wdata = v;
    ctl_load = 1'b1;
    tick(1);
    ctl_load = 1'b0;
  endtask
  task automatic load(logic [9:0] v);
    tmr_wdata = v;
    tmr_load = 1'b1;
    tick(1);
    tmr_load = 1'b0;
  endtask
  task automatic halt(logic [3:0] op);
    halt_operand = op;
    halt_req = 1'b1;
    tick(1);
    halt_req = 1'b0;
  endtask
  // sel 0 done, 1 run, 2 stopped; a bound used up ends the run
  task automatic wait_for(int sel, int bound, output int c);
    c = 0;
    while (st[sel] !== 1'b1) begin
      if (c == bound) begin
        miscompares++;
        $display("BAD wait %0d expected 1 seen 0", sel);
        print_verdict();
      end
      tick(1);
      c++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    {rst_n, tmr_load, ctl_load, halt_req, serial_in} = 5'h00;
    all_clear_n = 1'b1;
    {tmr_wdata, ctl_wdata, halt_operand} = 24'h000000;
    {press_scan, press_in} = 12'h000;
    tick(3);
    check("reset", {ir_carrier_out, tx_active_n, tmr_rdata}, 12'h400);
    check("reset ctl", {port_control[9:8], port_control[0]}, 12'h0);
    check("reset run", {cpu_run, osc_stopped}, 12'h2);
    rst_n = 1'b1;
    ctl(10'h033);
    check("fields", {rl_from_serial, serial_pull_en, key_scan_out_en,
      rom_ptr_hi}, 12'h1f);
    ctl(10'h020);
    check("fields", {serial_pull_en, key_scan_out_en, rom_ptr_hi}, 12'h2);
    load(10'h205);
    tick(40);
    check("held", {tmr_done, tmr_rdata}, 12'h205);
    for (int m = 0; m < 2; m++) begin
      ctl(m ? 10'h00c : 10'h004);
      load(10'h228);
      tick(8);
      check("activity", tx_active_n, 1'b0);
      p0 = pulses;
      tick(96);
      n = pulses - p0;
      check("rate", n >= (m ? 7 : 11) && n <= (m ? 9 : 13), 1'b1);
      wait_for(0, 400, n);
      check("count", n + 104 >= 320 && n + 104 <= 329, 1'b1);
      p0 = pulses;
      tick(24);
      check("idle", {ir_carrier_out, tx_active_n}, 12'h1);
      check("no pulses", pulses - p0, 12'h0);
    end
    load(10'h203);
    check("reload", {tmr_done, tmr_rdata[9]}, 12'h1);
    wait_for(0, 60, n);
    check("n plus one", n >= 24 && n <= 33, 1'b1);
    load(10'h200);
    wait_for(0, 20, n);
    check("zero load", n <= 9, 1'b1);
    load(10'h014);
    p0 = pulses;
    tick(16);
    check("no carrier", tx_active_n, 1'b1);
    wait_for(0, 200, n);
    check("no carrier", pulses - p0, 12'h0);
    load(10'h204);
    halt(4'h3);
    check("halted", cpu_run, 1'b0);
    wait_for(1, 60, n);
    check("timer wake", tmr_done, 1'b1);
    halt(4'h0);
    wait_for(1, 4, n);
    ctl(10'h005);
    halt(4'h8);
    tick(10);
    check("serial wait", cpu_run, 1'b0);
    serial_in = 1'b1;
    wait_for(1, 4, n);
    serial_in = 1'b0;
    for (int l = 0; l < 2; l++) begin
      press_in = l ? 4'h0 : 4'hf;
      halt({l[0], 3'h2});
      tick(10);
      check("key wait", cpu_run, 1'b0);
      press_in = l ? 4'h1 : 4'he;
      wait_for(1, 4, n);
      press_in = 4'h0;
      tick(1);
    end
    ctl(10'h006);
    halt(4'h9);
    tick(10);
    check("scan out", cpu_run, 1'b0);
    all_clear_n = 1'b0;
    tick(1);
    check("clear", {cpu_run, tmr_rdata}, 12'h400);
    all_clear_n = 1'b1;
    halt(4'h9);
    press_scan = 8'h10;
    wait_for(1, 4, n);
    press_scan = 8'h00;
    ctl(10'h044);
    load(10'h205);
    halt(4'ha);
    tick(16);
    check("stop wait", {osc_stopped, cpu_run}, 12'h0);
    wait_for(2, 60, n);
    check("stop late", tmr_done, 1'b1);
    press_in = 4'h1;
    wait_for(1, 8, n);
    check("stop left", osc_stopped, 1'b0);
    print_verdict();
  end
endmodule
